// ---- rtl/seg_pkg.sv ----
// Constants for the segment selector and translation unit.
// Assumes a 100 MHz core clock and a plain register port of 32-bit words.
// Function
// (RQ1) Each segment has own base, 1B-4GB size
// (RQ2) Compatibility mode wraps addresses at 4 Gbytes
// (RQ3) Software sets base 0, limit 4G for flat
// (RQ4) 64-bit mode uses zero base
// (RQ5) 64-bit mode skips limits and most attributes
// (RQ6) Code segment sets privilege, size, mode
// (RQ7) Extra base segments keep base in 64-bit
// (RQ8) Table and task registers used in all modes
// (RQ9) Selector load fetches descriptor into hidden part
// (RQ10) Descriptor address is table base plus index*8
// (RQ11) Index scaled by eight even for wide entries
// (RQ12) Table select bit picks global or local table
// (RQ13) Requester level bits 1:0 join privilege checks
// (RQ14) Null selector use faults outside 64-bit mode
// (RQ15) Null loads only into data and local table
// (RQ16) Null code load faults; stack conditionally faults
// (RQ17) Interrupt table indexed by vector number
// (RQ18) Table registers hold base and size
// (RQ19) Task pointer holds task segment base, limit
// (RQ20) 64-bit mode checks canonical address form
// (RQ21) Offset above limit faults outside 64-bit mode
`default_nettype none
package seg_pkg;
	// Register word offsets (byte addresses)
	localparam logic [7:0] OFF_SEL_BASE  = 8'h00; // six selectors, enc*4
	localparam logic [7:0] OFF_LDT_SEL   = 8'h18;
	localparam logic [7:0] OFF_GDT_BASE  = 8'h1c;
	localparam logic [7:0] OFF_GDT_LIMIT = 8'h20;
	localparam logic [7:0] OFF_IDT_BASE  = 8'h24;
	localparam logic [7:0] OFF_IDT_LIMIT = 8'h28;
	localparam logic [7:0] OFF_TR_BASE   = 8'h2c;
	localparam logic [7:0] OFF_TR_LIMIT  = 8'h30;
	localparam logic [7:0] OFF_CTRL      = 8'h34;
	localparam logic [7:0] OFF_STATUS    = 8'h38;
	localparam logic [7:0] OFF_FS_HI     = 8'h3c;
	localparam logic [7:0] OFF_GS_HI     = 8'h40;
	localparam logic [7:0] OFF_LDT_BASE  = 8'h44;
	localparam logic [7:0] OFF_LDT_LIMIT = 8'h48;

	// Segment register encodings
	localparam logic [2:0] SEG_ES  = 3'h0;
	localparam logic [2:0] SEG_CS  = 3'h1;
	localparam logic [2:0] SEG_SS  = 3'h2;
	localparam logic [2:0] SEG_DS  = 3'h3;
	localparam logic [2:0] SEG_FS  = 3'h4;
	localparam logic [2:0] SEG_GS  = 3'h5;
	localparam logic [2:0] SEG_LDT = 3'h6;

	// Selector fields
	localparam int SEL_TI      = 2;
	localparam int SEL_IDX_LSB = 3;
	localparam int SEL_RPL_MSB = 1;

	// Control and status bits
	localparam int CTRL_PROT   = 0;
	localparam int CTRL_LONG   = 1;
	localparam int ST_CPL_LSB  = 0;
	localparam int ST_MODE64   = 2;
	localparam int ST_OP32     = 3;
	localparam int ST_BUSY     = 4;
	localparam int ST_LD_FAULT = 5;
	localparam int ST_AC_FAULT = 6;

	// Descriptor word layout as fetched
	localparam int DSC_LIM_LSB = 32;
	localparam int DSC_LIM_MSB = 51;
	localparam int DSC_GRAN    = 52;
	localparam int DSC_DPL_LSB = 53;
	localparam int DSC_D       = 55;
	localparam int DSC_L       = 56;
	localparam int DSC_PRESENT = 57;

	localparam logic [31:0] ENTRY_BYTES = 32'h8;
	localparam logic [31:0] LIMIT_RESET = 32'h0000_ffff;
	localparam logic [1:0]  PRIV_USER   = 2'h3;

	typedef enum logic [0:0] {
		LD_IDLE  = 1'b0,
		LD_FETCH = 1'b1
	} load_state_t;
endpackage
`default_nettype wire

// ---- rtl/seg_addr_check.sv ----
// Address formation and checking for one segment access.
// Purely combinational; the caller registers the results.
`timescale 1ns/100ps
`default_nettype none
module seg_addr_check #(
	parameter int VA_BITS = 48
) (
	// Mode
	input  wire logic        mode64,
	input  wire logic        keeps_base,
	// Hidden segment state
	input  wire logic [63:0] seg_base,
	input  wire logic [31:0] seg_limit,
	input  wire logic        seg_null,
	// Access
	input  wire logic [63:0] offset,
	output logic      [63:0] lin_addr,
	output logic             fault
);
	logic [63:0] eff_base;
	logic [31:0] lin32;
	logic [63:0] lin64;
	logic        canon;

	// Base choice per mode
	always_comb begin
		eff_base = {32'h0, seg_base[31:0]};
		if (mode64) begin
			// (RQ4) zero base in 64-bit
			eff_base = 64'h0;
			// (RQ7) extra bases still added
			if (keeps_base)
				eff_base = seg_base;
		end
	end

	// Segmented sum stays inside the low 4 Gbytes
	// (RQ2) compatibility 32-bit wrap
	assign lin32 = seg_base[31:0] + offset[31:0];

	// Flat sum kept apart so the canonical test never feeds on lin_addr
	assign lin64 = eff_base + offset;

	// Upper bits must all copy the top implemented bit
	assign canon = (lin64[63:VA_BITS-1] == '0)
		|| (lin64[63:VA_BITS-1] == '1);

	always_comb begin
		if (mode64) begin
			lin_addr = lin64;
			// (RQ20) canonical check instead
			// (RQ5) no limit or null check
			fault = !canon;
		end else begin
			lin_addr = {32'h0, lin32};
			// (RQ14) null use faults
			// (RQ21) limit check outside 64-bit
			fault = seg_null || (offset[63:32] != 32'h0)
				|| (offset[31:0] > seg_limit);
		end
	end
endmodule // seg_addr_check
`default_nettype wire

// ---- rtl/seg_unit.sv ----
// Segment selector load, descriptor fetch and address translation.
// Assumes a descriptor read port that answers with one ack pulse,
// and an execution unit that issues one access at a time.
`timescale 1ns/100ps
`default_nettype none
module seg_unit #(
	parameter int VA_BITS = 48
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Descriptor fetch
	output logic             desc_req,
	output logic      [63:0] desc_addr,
	input  wire logic        desc_ack,
	input  wire logic [63:0] desc_data,
	// Load result
	output logic             load_done,
	output logic             load_fault,
	// Address generation
	input  wire logic        acc_valid,
	input  wire logic [2:0]  acc_seg,
	input  wire logic [63:0] acc_offset,
	output logic             acc_done,
	output logic      [63:0] acc_lin_addr,
	output logic             acc_fault,
	// Interrupt table lookup
	input  wire logic [7:0]  int_vector,
	output logic      [63:0] int_desc_addr,
	// Core state
	output logic      [1:0]  current_priv_level,
	output logic             mode64,
	output logic             default_op32
);
	// Hidden portions, index by encoding, slot 6 is the local table
	logic [15:0] sel_reg    [0:6];
	logic [63:0] base_reg   [0:6];
	logic [31:0] limit_reg  [0:6];
	logic [1:0]  dpl_reg    [0:6];
	logic        null_reg   [0:6];
	logic        cs_d_reg;
	logic        cs_l_reg;
	// System segment registers
	logic [31:0] global_table_base_reg;
	logic [31:0] global_table_limit_reg;
	logic [31:0] interrupt_table_base_reg;
	logic [31:0] interrupt_table_limit_reg;
	logic [31:0] task_state_base_reg;
	logic [31:0] task_state_limit_reg;
	// Control and status
	logic        prot_en_reg;
	logic        long_active_reg;
	logic [1:0]  cpl_reg;
	logic        ld_fault_reg;
	logic        ac_fault_reg;
	// Load sequencer
	seg_pkg::load_state_t state_reg;
	logic [2:0]  ld_seg_reg;
	logic [15:0] ld_sel_reg;
	logic [63:0] desc_addr_reg;

	// Write decode
	logic        sel_wr;
	logic [2:0]  wr_seg;
	logic [15:0] new_sel;
	logic        new_null;
	logic [31:0] tbl_base;
	logic [31:0] tbl_limit;
	logic [31:0] entry_off;
	logic        start_load;
	logic        early_fault;
	logic        fetch_fault;
	logic [31:0] dsc_limit;
	logic [1:0]  dsc_dpl;
	logic [1:0]  requester_priv_level;
	logic [1:0]  eff_priv;
	logic        status_clr;
	logic        chk_fault;
	logic [63:0] chk_lin;
	logic        chk_keeps;

	assign wr_seg  = (reg_addr == seg_pkg::OFF_LDT_SEL) ? seg_pkg::SEG_LDT
		: reg_addr[4:2];
	assign sel_wr  = reg_wr && (reg_addr[1:0] == 2'h0)
		&& (reg_addr <= seg_pkg::OFF_LDT_SEL);
	assign new_sel = reg_wdata[15:0];
	// (RQ14) null is index 0 in global table
	assign new_null = (new_sel[15:seg_pkg::SEL_TI] == 14'h0);

	// (RQ12) table select picks base
	// (RQ8) table registers used in all modes
	assign tbl_base  = new_sel[seg_pkg::SEL_TI]
		? base_reg[seg_pkg::SEG_LDT][31:0] : global_table_base_reg;
	assign tbl_limit = new_sel[seg_pkg::SEL_TI]
		? limit_reg[seg_pkg::SEG_LDT] : global_table_limit_reg;
	// (RQ10) index times eight
	// (RQ11) scale stays eight in long mode
	assign entry_off = {16'h0, new_sel[15:seg_pkg::SEL_IDX_LSB], 3'h0};

	// Faults found before any fetch: null rules and table bounds
	always_comb begin
		early_fault = 1'b0;
		if (new_null) begin
			// (RQ15) null only into data and local table
			// (RQ16) null code always faults, stack conditionally
			if (wr_seg == seg_pkg::SEG_CS)
				early_fault = 1'b1;
			else if (wr_seg == seg_pkg::SEG_SS)
				early_fault = !mode64
					|| (cpl_reg == seg_pkg::PRIV_USER);
		end else begin
			// Entry must lie fully inside the chosen table
			if (entry_off + seg_pkg::ENTRY_BYTES - 32'h1 > tbl_limit)
				early_fault = 1'b1;
			// Local selector with a null local table
			if (new_sel[seg_pkg::SEL_TI] && null_reg[seg_pkg::SEG_LDT])
				early_fault = 1'b1;
		end
	end

	assign start_load = sel_wr && (state_reg == seg_pkg::LD_IDLE)
		&& prot_en_reg;

	// Descriptor fields and privilege checks at fetch end
	assign dsc_limit = desc_data[seg_pkg::DSC_GRAN]
		? {desc_data[seg_pkg::DSC_LIM_MSB:seg_pkg::DSC_LIM_LSB], 12'hfff}
		: {12'h0, desc_data[seg_pkg::DSC_LIM_MSB:seg_pkg::DSC_LIM_LSB]};
	assign dsc_dpl = desc_data[seg_pkg::DSC_DPL_LSB+1:seg_pkg::DSC_DPL_LSB];
	assign requester_priv_level     = ld_sel_reg[seg_pkg::SEL_RPL_MSB:0];
	assign eff_priv = (requester_priv_level > cpl_reg) ? requester_priv_level : cpl_reg;

	always_comb begin
		fetch_fault = !desc_data[seg_pkg::DSC_PRESENT];
		// (RQ13) requester level in checks
		if (ld_seg_reg == seg_pkg::SEG_SS)
			fetch_fault = fetch_fault || (requester_priv_level != cpl_reg)
				|| (dsc_dpl != cpl_reg);
		else if (ld_seg_reg != seg_pkg::SEG_CS
			&& ld_seg_reg != seg_pkg::SEG_LDT)
			fetch_fault = fetch_fault || (eff_priv > dsc_dpl);
	end

	// Load sequencer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg     <= seg_pkg::LD_IDLE;
			ld_seg_reg    <= 3'h0;
			ld_sel_reg    <= 16'h0;
			desc_addr_reg <= 64'h0;
		end else begin
			unique case (state_reg)
				seg_pkg::LD_IDLE: begin
					// (RQ9) selector write starts a fetch
					if (start_load && !new_null && !early_fault) begin
						state_reg     <= seg_pkg::LD_FETCH;
						ld_seg_reg    <= wr_seg;
						ld_sel_reg    <= new_sel;
						desc_addr_reg <= {32'h0, tbl_base + entry_off};
					end
				end
				seg_pkg::LD_FETCH: begin
					if (desc_ack)
						state_reg <= seg_pkg::LD_IDLE;
				end
			endcase
		end
	end

	assign desc_req  = (state_reg == seg_pkg::LD_FETCH);
	assign desc_addr = desc_addr_reg;

	// Load completion pulses
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			load_done  <= 1'b0;
			load_fault <= 1'b0;
		end else begin
			load_done  <= 1'b0;
			load_fault <= 1'b0;
			if (start_load && (new_null || early_fault)) begin
				load_done  <= 1'b1;
				load_fault <= early_fault;
			end else if (desc_req && desc_ack) begin
				load_done  <= 1'b1;
				load_fault <= fetch_fault;
			end
		end
	end

	// Hidden portions: selector, base, limit, attributes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < 7; i++) begin
				sel_reg[i]   <= 16'h0;
				base_reg[i]  <= 64'h0;
				limit_reg[i] <= seg_pkg::LIMIT_RESET;
				dpl_reg[i]   <= 2'h0;
				null_reg[i]  <= 1'b0;
			end
			cs_d_reg <= 1'b0;
			cs_l_reg <= 1'b0;
		end else begin
			if (start_load && new_null && !early_fault) begin
				sel_reg[wr_seg]  <= new_sel;
				null_reg[wr_seg] <= 1'b1;
			end else if (desc_req && desc_ack && !fetch_fault) begin
				// (RQ1) own base and size per segment
				sel_reg[ld_seg_reg]   <= ld_sel_reg;
				base_reg[ld_seg_reg]  <= {32'h0, desc_data[31:0]};
				limit_reg[ld_seg_reg] <= dsc_limit;
				dpl_reg[ld_seg_reg]   <= dsc_dpl;
				null_reg[ld_seg_reg]  <= 1'b0;
				if (ld_seg_reg == seg_pkg::SEG_CS) begin
					cs_d_reg <= desc_data[seg_pkg::DSC_D];
					cs_l_reg <= desc_data[seg_pkg::DSC_L];
				end
			end else if (reg_wr && reg_addr == seg_pkg::OFF_FS_HI) begin
				base_reg[seg_pkg::SEG_FS][63:32] <= reg_wdata;
			end else if (reg_wr && reg_addr == seg_pkg::OFF_GS_HI) begin
				base_reg[seg_pkg::SEG_GS][63:32] <= reg_wdata;
			end
		end
	end

	// (RQ6) code segment sets privilege, size, mode
	always_ff @(posedge clk_sys) begin
		if (rst)
			cpl_reg <= 2'h0;
		else if (desc_req && desc_ack && !fetch_fault
			&& ld_seg_reg == seg_pkg::SEG_CS)
			cpl_reg <= dsc_dpl;
	end
	assign mode64       = long_active_reg && cs_l_reg;
	assign default_op32 = cs_d_reg;
	assign current_priv_level = cpl_reg;

	// System segment and control registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			global_table_base_reg     <= 32'h0;
			global_table_limit_reg    <= seg_pkg::LIMIT_RESET;
			interrupt_table_base_reg  <= 32'h0;
			interrupt_table_limit_reg <= seg_pkg::LIMIT_RESET;
			task_state_base_reg       <= 32'h0;
			task_state_limit_reg      <= 32'h0;
			prot_en_reg               <= 1'b0;
			long_active_reg           <= 1'b0;
		end else if (reg_wr) begin
			// (RQ18) table base and size
			// (RQ19) task segment location and limit
			unique case (reg_addr)
				seg_pkg::OFF_GDT_BASE:  global_table_base_reg <= reg_wdata;
				seg_pkg::OFF_GDT_LIMIT: global_table_limit_reg <= reg_wdata;
				seg_pkg::OFF_IDT_BASE:  interrupt_table_base_reg <= reg_wdata;
				seg_pkg::OFF_IDT_LIMIT:
					interrupt_table_limit_reg <= reg_wdata;
				seg_pkg::OFF_TR_BASE:   task_state_base_reg <= reg_wdata;
				seg_pkg::OFF_TR_LIMIT:  task_state_limit_reg <= reg_wdata;
				seg_pkg::OFF_CTRL: begin
					prot_en_reg     <= reg_wdata[seg_pkg::CTRL_PROT];
					long_active_reg <= reg_wdata[seg_pkg::CTRL_LONG];
				end
				default: ;
			endcase
		end
	end

	// (RQ17) interrupt table indexed by vector
	assign int_desc_addr = {32'h0, interrupt_table_base_reg}
		+ (long_active_reg ? {52'h0, int_vector, 4'h0}
			: {53'h0, int_vector, 3'h0});

	// Address check for the requested segment
	assign chk_keeps = (acc_seg == seg_pkg::SEG_FS)
		|| (acc_seg == seg_pkg::SEG_GS);

	seg_addr_check #(
		.VA_BITS (VA_BITS)
	) u_check (
		.mode64     (mode64),
		.keeps_base (chk_keeps),
		.seg_base   (base_reg[acc_seg]),
		.seg_limit  (limit_reg[acc_seg]),
		.seg_null   (null_reg[acc_seg]),
		.offset     (acc_offset),
		.lin_addr   (chk_lin),
		.fault      (chk_fault)
	);

	// Access result, one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			acc_done     <= 1'b0;
			acc_lin_addr <= 64'h0;
			acc_fault    <= 1'b0;
		end else begin
			acc_done <= acc_valid;
			if (acc_valid) begin
				acc_lin_addr <= chk_lin;
				acc_fault    <= chk_fault || (acc_seg > seg_pkg::SEG_GS);
			end
		end
	end

	// Sticky fault flags, set wins over clear
	assign status_clr = reg_wr && (reg_addr == seg_pkg::OFF_STATUS);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ld_fault_reg <= 1'b0;
			ac_fault_reg <= 1'b0;
		end else begin
			if (load_fault)
				ld_fault_reg <= 1'b1;
			else if (status_clr && reg_wdata[seg_pkg::ST_LD_FAULT])
				ld_fault_reg <= 1'b0;
			if (acc_done && acc_fault)
				ac_fault_reg <= 1'b1;
			else if (status_clr && reg_wdata[seg_pkg::ST_AC_FAULT])
				ac_fault_reg <= 1'b0;
		end
	end

	// Read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			reg_rdata <= 32'h0;
			if (reg_addr[1:0] == 2'h0 && reg_addr <= seg_pkg::OFF_LDT_SEL)
				reg_rdata <= {16'h0, sel_reg[wr_seg]};
			unique case (reg_addr)
				seg_pkg::OFF_GDT_BASE:  reg_rdata <= global_table_base_reg;
				seg_pkg::OFF_GDT_LIMIT: reg_rdata <= global_table_limit_reg;
				seg_pkg::OFF_IDT_BASE:  reg_rdata <= interrupt_table_base_reg;
				seg_pkg::OFF_IDT_LIMIT:
					reg_rdata <= interrupt_table_limit_reg;
				seg_pkg::OFF_TR_BASE:   reg_rdata <= task_state_base_reg;
				seg_pkg::OFF_TR_LIMIT:  reg_rdata <= task_state_limit_reg;
				seg_pkg::OFF_CTRL:
					reg_rdata <= {30'h0, long_active_reg, prot_en_reg};
				seg_pkg::OFF_STATUS:
					reg_rdata <= {25'h0, ac_fault_reg, ld_fault_reg,
						desc_req, default_op32, mode64, cpl_reg};
				seg_pkg::OFF_FS_HI:
					reg_rdata <= base_reg[seg_pkg::SEG_FS][63:32];
				seg_pkg::OFF_GS_HI:
					reg_rdata <= base_reg[seg_pkg::SEG_GS][63:32];
				seg_pkg::OFF_LDT_BASE:
					reg_rdata <= base_reg[seg_pkg::SEG_LDT][31:0];
				seg_pkg::OFF_LDT_LIMIT:
					reg_rdata <= limit_reg[seg_pkg::SEG_LDT];
				default: ;
			endcase
		end
	end
endmodule // seg_unit
`default_nettype wire

// ---- verification/desc_mem_model.sv ----
// Descriptor memory standing on the far side of the fetch port.
// Assumes one fetch at a time; entries are made from the address.
`timescale 1ns/100ps
`default_nettype none
module desc_mem_model (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Answer speed, 0 prompt and 1 slow
	input  wire logic        slow,
	// Fetch port
	input  wire logic        desc_req,
	input  wire logic [63:0] desc_addr,
	output logic             desc_ack,
	output logic      [63:0] desc_data
);
	logic [1:0] wait_cnt;

	// Slot 2 flat, slot 4 long code, others small data segments
	function automatic logic [63:0] entry(input logic [63:0] a);
		logic flat;
		logic lng;
		flat = a[5:3] == 3'h2;
		lng  = a[5:3] == 3'h4;
		entry = {6'h0, 1'b1, lng, !lng, 2'h0, flat,
			flat ? 20'hfffff : 20'h00fff, flat ? 32'h0 : {a[15:0], 16'h0}};
	endfunction

	// Answer once per request; data churns so stale values never pass
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			desc_ack  <= 1'b0;
			desc_data <= 64'h0;
			wait_cnt  <= 2'h0;
		end else if (desc_req && !desc_ack && (!slow || wait_cnt == 2'h3)) begin
			desc_ack  <= 1'b1;
			desc_data <= entry(desc_addr);
			wait_cnt  <= 2'h0;
		end else begin
			desc_ack  <= 1'b0;
			desc_data <= ~desc_data;
			wait_cnt  <= desc_req ? wait_cnt + 2'h1 : 2'h0;
		end
	end
endmodule // desc_mem_model
`default_nettype wire

// ---- verification/seg_unit_assertions.sv ----
// Port-level assertions for the segment unit.
// Assumes 32-bit table base registers and one selector load at a time.
`timescale 1ns/100ps
`default_nettype none
module seg_unit_checker #(
	parameter int VA_BITS = 48
) (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        desc_req,
	input wire logic [63:0] desc_addr,
	input wire logic        desc_ack,
	input wire logic        load_done,
	input wire logic        load_fault,
	input wire logic        acc_valid,
	input wire logic [2:0]  acc_seg,
	input wire logic [63:0] acc_offset,
	input wire logic        acc_done,
	input wire logic [63:0] acc_lin_addr,
	input wire logic        acc_fault,
	input wire logic [7:0]  int_vector,
	input wire logic [63:0] int_desc_addr,
	input wire logic        mode64
);
	logic        prot_reg;
	logic        long_reg;
	logic [31:0] gdt_reg;
	logic [31:0] idt_reg;
	logic [15:0] sel_reg;
	logic        canon;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Shadow of the registers the checks lean on
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prot_reg <= 1'b0;
			long_reg <= 1'b0;
			gdt_reg  <= 32'h0;
			idt_reg  <= 32'h0;
		end else if (reg_wr) begin
			if (reg_addr == seg_pkg::OFF_CTRL) begin
				prot_reg <= reg_wdata[seg_pkg::CTRL_PROT];
				long_reg <= reg_wdata[seg_pkg::CTRL_LONG];
			end
			if (reg_addr == seg_pkg::OFF_GDT_BASE) gdt_reg <= reg_wdata;
			if (reg_addr == seg_pkg::OFF_IDT_BASE) idt_reg <= reg_wdata;
		end
	end

	// Last written word; a fetch starts the cycle after the selector write that asks for it
	always_ff @(posedge clk_sys) begin
		if (reg_wr) sel_reg <= reg_wdata[15:0];
	end

	// Top address bits all equal
	assign canon = &acc_offset[63:VA_BITS-1] || ~|acc_offset[63:VA_BITS-1];

	desc_hold_a: assert property (
		desc_req && !desc_ack |=> desc_req && $stable(desc_addr))
		else $error("fetch request dropped or moved");
	load_end_a: assert property (
		desc_req && desc_ack |=> load_done && !desc_req ##1 !load_done)
		else $error("load end wrong");
	desc_addr_a: assert property (
		$rose(desc_req) && !sel_reg[seg_pkg::SEL_TI] |->
		desc_addr == {32'h0, gdt_reg} + {48'h0, sel_reg[15:3], 3'h0})
		else $error("descriptor address wrong");
	null_code_a: assert property (
		reg_wr && reg_addr == 8'h04 && reg_wdata[15:2] == 14'h0 && prot_reg
		&& !desc_req |=> load_done && load_fault)
		else $error("null code load accepted");
	null_stack_a: assert property (
		reg_wr && reg_addr == 8'h08 && reg_wdata[15:2] == 14'h0 && prot_reg
		&& !desc_req && !mode64 |=> load_done && load_fault)
		else $error("null stack load accepted");
	null_data_a: assert property (
		reg_wr && reg_addr == 8'h0c && reg_wdata[15:2] == 14'h0 && prot_reg
		&& !desc_req |=> load_done && !load_fault)
		else $error("null data load refused");
	zero_base_a: assert property (
		acc_valid && mode64 && canon && acc_seg < seg_pkg::SEG_FS |=>
		acc_done && acc_lin_addr == $past(acc_offset))
		else $error("base used in 64-bit mode");
	canon_ok_a: assert property (
		acc_valid && mode64 && canon && acc_seg <= seg_pkg::SEG_GS |=>
		!acc_fault)
		else $error("limit applied in 64-bit mode");
	canon_bad_a: assert property (
		acc_valid && mode64 && !canon |=> acc_done && acc_fault)
		else $error("non-canonical access passed");
	low_space_a: assert property (
		acc_valid && !mode64 |=> acc_fault || acc_lin_addr[63:32] == 32'h0)
		else $error("address above 4G outside 64-bit mode");
	high_off_a: assert property (
		acc_valid && !mode64 && acc_offset[63:32] != 32'h0 |=> acc_fault)
		else $error("offset over limit passed");
	int_index_a: assert property (
		!long_reg |->
		int_desc_addr == {32'h0, idt_reg} + {53'h0, int_vector, 3'h0})
		else $error("interrupt entry address wrong");
endmodule // seg_unit_checker

bind seg_unit seg_unit_checker #(.VA_BITS(VA_BITS)) i_seg_unit_checker (
	.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .desc_req, .desc_addr,
	.desc_ack, .load_done, .load_fault, .acc_valid, .acc_seg, .acc_offset,
	.acc_done, .acc_lin_addr, .acc_fault, .int_vector, .int_desc_addr,
	.mode64);
`default_nettype wire

// ---- verification/seg_unit_test.sv ----
// Self-checking bench for the segment unit with a descriptor memory model.
// Assumes table base 0x1000 and the entry layout of the memory model.
`timescale 1ns/100ps
`default_nettype none
module seg_unit_test;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        desc_req, desc_ack, load_done, load_fault, slow = 1'b0;
	logic [63:0] desc_addr, desc_data, acc_lin_addr, int_desc_addr;
	logic        acc_valid = 1'b0;
	logic [2:0]  acc_seg = 3'h0;
	logic [63:0] acc_offset = 64'h0;
	logic        acc_done, acc_fault, mode64, default_op32;
	logic [7:0]  int_vector = 8'h0;
	logic [1:0]  current_priv_level;
	integer      seed, i;
	int          error_cnt = 0;
	int          checks = 0;
	logic [31:0] r;
	logic [63:0] r64;

	seg_unit i_seg_unit (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .desc_req, .desc_addr, .desc_ack, .desc_data,
		.load_done, .load_fault, .acc_valid, .acc_seg, .acc_offset, .acc_done,
		.acc_lin_addr, .acc_fault, .int_vector, .int_desc_addr,
		.current_priv_level, .mode64, .default_op32);
	desc_mem_model i_desc_mem_model (.clk_sys, .rst, .slow, .desc_req,
		.desc_addr, .desc_ack, .desc_data);

	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		if (error_cnt == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Base an entry of the memory model carries
	function automatic logic [63:0] base_of(input logic [63:0] a);
		base_of = a[5:3] == 3'h2 ? 64'h0 : {32'h0, a[15:0], 16'h0};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask

	// Selector load; ea is the fetch address, zero when none is due
	task automatic ld(input logic [7:0] a, input logic [15:0] s,
		input logic f, input logic [63:0] ea);
		logic seen;
		seen = 1'b0;
		@(posedge clk_sys);
		slow <= 1'($random(seed));
		wr(a, {16'h0, s});
		repeat (20) begin
			#1;
			if (desc_req === 1'b1 && !seen) begin
				seen = 1'b1;
				chk(desc_addr, ea);
			end
			if (load_done === 1'b1) break;
			@(posedge clk_sys);
		end
		chk(seen, ea != 64'h0);
		chk(load_done, 1'b1);
		chk(load_fault, f);
	endtask

	task automatic acc(input logic [2:0] sg, input logic [63:0] off,
		input logic [63:0] ea, input logic f);
		@(posedge clk_sys);
		acc_valid  <= 1'b1;
		acc_seg    <= sg;
		acc_offset <= off;
		@(posedge clk_sys);
		acc_valid <= 1'b0;
		#1;
		chk(acc_done, 1'b1);
		chk(acc_fault, f);
		if (!f) chk(acc_lin_addr, ea);
	endtask

	// Main sequence
	initial begin
		seed = 26;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rd(seg_pkg::OFF_GDT_LIMIT, 32'h0000_ffff);
		rd(seg_pkg::OFF_TR_LIMIT, 32'h0);
		r = $random(seed);
		wr(seg_pkg::OFF_TR_BASE, r);
		rd(seg_pkg::OFF_TR_BASE, r);
		rd(8'hfc, 32'h0);
		wr(seg_pkg::OFF_GDT_BASE, 32'h1000);
		wr(seg_pkg::OFF_IDT_BASE, 32'h2000);
		@(posedge clk_sys);
		int_vector <= r[7:0];
		#1;
		chk(int_desc_addr, 64'h2000 + {r[7:0], 3'h0});
		wr(seg_pkg::OFF_CTRL, 32'h1);
		ld(8'h0c, 16'h0010, 1'b0, 64'h1010);
		acc(seg_pkg::SEG_DS, 64'hffff_ffff, 64'hffff_ffff, 1'b0);
		acc(seg_pkg::SEG_DS, 64'h1_0000_0000, 64'h0, 1'b1);
		ld(8'h00, 16'h0018, 1'b0, 64'h1018);
		for (i = 0; i < 8; i++) begin
			r64 = {51'h0, 13'($random(seed))};
			acc(seg_pkg::SEG_ES, r64, base_of(64'h1018) + r64, r64 > 64'hfff);
		end
		ld(8'h04, 16'h0000, 1'b1, 64'h0);
		ld(8'h08, 16'h0000, 1'b1, 64'h0);
		ld(8'h08, 16'h0013, 1'b1, 64'h1010);
		ld(8'h08, 16'h0010, 1'b0, 64'h1010);
		ld(seg_pkg::OFF_LDT_SEL, 16'h0018, 1'b0, 64'h1018);
		ld(8'h14, 16'h000c, 1'b0, 64'h1018_0008);
		acc(seg_pkg::SEG_GS, 64'h10, base_of(64'h1018_0008) + 64'h10, 1'b0);
		ld(8'h10, 16'h0018, 1'b0, 64'h1018);
		wr(seg_pkg::OFF_FS_HI, 32'h1);
		acc(seg_pkg::SEG_FS, 64'h20, base_of(64'h1018) + 64'h20, 1'b0);
		ld(8'h0c, 16'h0000, 1'b0, 64'h0);
		rd(8'h0c, 32'h0);
		acc(seg_pkg::SEG_DS, 64'h4, 64'h0, 1'b1);
		ld(8'h04, 16'h0020, 1'b0, 64'h1020);
		wr(seg_pkg::OFF_CTRL, 32'h3);
		#1;
		chk(mode64, 1'b1);
		chk(default_op32, 1'b0);
		chk(current_priv_level, 2'h0);
		chk(int_desc_addr, 64'h2000 + {r[7:0], 4'h0});
		for (i = 0; i < 4; i++) begin
			r64 = {$random(seed), $random(seed)};
			r64 = {{18{r64[46]}}, r64[45:0]};
			acc(seg_pkg::SEG_ES, r64, r64, 1'b0);
			acc(seg_pkg::SEG_FS, r64, r64 + 64'h1_1018_0000, 1'b0);
		end
		acc(seg_pkg::SEG_DS, 64'h8, 64'h8, 1'b0);
		acc(seg_pkg::SEG_CS, 64'h0000_8000_0000_0000, 64'h0, 1'b1);
		ld(8'h08, 16'h0000, 1'b0, 64'h0);
		ld(8'h00, 16'h0018, 1'b0, 64'h1018);
		// Sticky load and access faults, 64-bit mode, level 0, idle
		rd(seg_pkg::OFF_STATUS, 32'h0000_0064);
		stop_test;
	end

	// Watchdog, far beyond the 130 to 160 cycles the run needs
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		stop_test;
	end
endmodule // seg_unit_test
`default_nettype wire
